// *** hdl/led_string_fault_status_regs.sv ***
// string fault status registers with unused-string masking and fault flag
//
// Operation
// - host sets string one unused flag (bit 7); device masks its faults
// - unused strings leave detection, status bits and the fault flag
// - write acknowledge is given at the same edge that masking takes effect, never before
// - host sets string two unused flag (bit 6); device masks its faults
// - over-voltage bit high while drain above threshold; bits 5 and 2
// - open bit set when string is open; bits 4 and 1
// - unused status bit reads one while string unused; bits 3 and 0
// - strings three and four share the same status layout
// - strings one and two status decoded at register index 05h
// - active-low fault flag is the NOR of all unmasked faults
`timescale 1ns/1ps
`default_nettype none
module led_string_fault_status_regs
  import led_status_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire reg_req_type      req,
  input  wire string_sense_type sense,
  input  wire logic             other_fault,
  output var  logic [7:0]       read_data,
  output var  logic             write_ack,
  output var  logic             fault_flag_n
);
  logic [num_strings-1:0] unused_flag;
  logic [num_strings-1:0] ov_status;
  logic [num_strings-1:0] open_status;
  logic [num_strings-1:0] next_unused_flag;
  logic [num_strings-1:0] next_ov_status;
  logic [num_strings-1:0] next_open_status;
  logic [7:0]             next_read_data;
  logic [7:0]             reg_one_two;
  logic [7:0]             reg_three_four;
  logic                   hit_one_two;
  logic                   hit_three_four;
  logic                   any_fault;

  assign hit_one_two    = req.index == strings_one_two_index;
  assign hit_three_four = req.index == strings_three_four_index;

  // only the two top bits are writable; status bits ignore bus writes
  assign next_unused_flag[0] = (req.write_en && hit_one_two) ?
    req.data[first_unused_flag] : unused_flag[0];
  assign next_unused_flag[1] = (req.write_en && hit_one_two) ?
    req.data[second_unused_flag] : unused_flag[1];
  assign next_unused_flag[2] = (req.write_en && hit_three_four) ?
    req.data[first_unused_flag] : unused_flag[2];
  assign next_unused_flag[3] = (req.write_en && hit_three_four) ?
    req.data[second_unused_flag] : unused_flag[3];

  // masking uses the flag being written (next_unused_flag), so a fault seen in the write
  // cycle is already dropped at the same edge that raises the ack
  assign next_ov_status   = sense.overvoltage & ~next_unused_flag;
  assign next_open_status = sense.open & ~next_unused_flag;

  function automatic logic [7:0] pack_pair(input logic [1:0] flag,
                                           input logic [1:0] ov,
                                           input logic [1:0] op);
    logic [7:0] r;
    r = status_reset_value;
    r[first_unused_flag]  = flag[0];
    r[second_unused_flag] = flag[1];
    r[first_ov_bit]       = ov[0];
    r[first_open_bit]     = op[0];
    r[first_unused_bit]   = flag[0];
    r[second_ov_bit]      = ov[1];
    r[second_open_bit]    = op[1];
    r[second_unused_bit]  = flag[1];
    return r;
  endfunction

  assign reg_one_two    = pack_pair(unused_flag[1:0], ov_status[1:0],
                                    open_status[1:0]);
  assign reg_three_four = pack_pair(unused_flag[3:2], ov_status[3:2],
                                    open_status[3:2]);
  assign next_read_data = !req.read_en ? read_data :
                          hit_one_two ? reg_one_two :
                          hit_three_four ? reg_three_four :
                          status_reset_value;
  assign any_fault = (|next_ov_status) | (|next_open_status) | other_fault;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      unused_flag  <= '0;
      ov_status    <= '0;
      open_status  <= '0;
      read_data    <= status_reset_value;
      write_ack    <= 1'b0;
      fault_flag_n <= 1'b1;
    end else begin
      unused_flag  <= next_unused_flag;
      ov_status    <= next_ov_status;
      open_status  <= next_open_status;
      read_data    <= next_read_data;
      // ack leaves with the mask in the same edge, never before it
      write_ack    <= req.write_en && (hit_one_two || hit_three_four);
      fault_flag_n <= ~any_fault;
    end
  end

  property p_mask_before_ack;
    @(posedge mclk) disable iff (!rstn)
      write_ack |-> ((ov_status & unused_flag) == '0) &&
                    ((open_status & unused_flag) == '0);
  endproperty
  a_mask_before_ack: assert property (p_mask_before_ack)
    else $error("ack seen while a masked string still shows a fault");

  property p_flag_one;
    @(posedge mclk) disable iff (!rstn)
      req.write_en && hit_one_two |=>
        unused_flag[0] == $past(req.data[first_unused_flag]);
  endproperty
  a_flag_one: assert property (p_flag_one)
    else $error("string one unused flag did not take written value");

  property p_flag_two;
    @(posedge mclk) disable iff (!rstn)
      req.write_en && hit_one_two |=>
        unused_flag[1] == $past(req.data[second_unused_flag]);
  endproperty
  a_flag_two: assert property (p_flag_two)
    else $error("string two unused flag did not take written value");

  property p_flag_three_four;
    @(posedge mclk) disable iff (!rstn)
      req.write_en && hit_three_four |=>
        unused_flag[3] == $past(req.data[second_unused_flag]) &&
        unused_flag[2] == $past(req.data[first_unused_flag]);
  endproperty
  a_flag_three_four: assert property (p_flag_three_four)
    else $error("strings three and four unused flags wrong");

  property p_masked_zero;
    @(posedge mclk) disable iff (!rstn)
      ((ov_status | open_status) & unused_flag) == '0;
  endproperty
  a_masked_zero: assert property (p_masked_zero)
    else $error("masked string shows a fault bit");

  property p_ov_follows;
    @(posedge mclk) disable iff (!rstn)
      sense.overvoltage[0] && !next_unused_flag[0] |=> ov_status[0];
  endproperty
  a_ov_follows: assert property (p_ov_follows)
    else $error("over-voltage not reported for string one");

  property p_open_follows;
    @(posedge mclk) disable iff (!rstn)
      sense.open[3] && !next_unused_flag[3] |=> open_status[3];
  endproperty
  a_open_follows: assert property (p_open_follows)
    else $error("open not reported for string four");

  property p_read_one_two;
    @(posedge mclk) disable iff (!rstn)
      req.read_en && hit_one_two |=>
        read_data[first_unused_bit] == $past(unused_flag[0]) &&
        read_data[second_unused_bit] == $past(unused_flag[1]);
  endproperty
  a_read_one_two: assert property (p_read_one_two)
    else $error("unused status bits read back wrong");

  property p_flag_nor;
    @(posedge mclk) disable iff (!rstn)
      !fault_flag_n |-> $past(other_fault) || (|ov_status) || (|open_status);
  endproperty
  a_flag_nor: assert property (p_flag_nor)
    else $error("fault flag low without unmasked fault");

  // a mask write takes two edges: the request, then ack and mask together
  sequence s_mask_write;
    req.write_en && (hit_one_two || hit_three_four);
  endsequence

  sequence s_ack_with_mask;
    write_ack && (unused_flag == $past(next_unused_flag));
  endsequence

  property p_write_acked;
    @(posedge mclk) disable iff (!rstn)
      s_mask_write |=> s_ack_with_mask;
  endproperty
  a_write_acked: assert property (p_write_acked)
    else $error("mask write not acknowledged with mask in force");

  property p_ack_pulse;
    @(posedge mclk) disable iff (!rstn)
      write_ack |-> $past(req.write_en) &&
                    ($past(hit_one_two) || $past(hit_three_four));
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack given without a mask write");

  // a write to any other index must neither ack nor touch the flags
  property p_refused_write;
    @(posedge mclk) disable iff (!rstn)
      req.write_en && !hit_one_two && !hit_three_four |=>
        !write_ack && (unused_flag == $past(unused_flag));
  endproperty
  a_refused_write: assert property (p_refused_write)
    else $error("write to unmapped index had an effect");

  // with every string masked only the other faults may pull the flag
  property p_flag_masked;
    @(posedge mclk) disable iff (!rstn)
      (&next_unused_flag) && !other_fault |=> fault_flag_n;
  endproperty
  a_flag_masked: assert property (p_flag_masked)
    else $error("fault flag low with all strings masked");

  property p_read_three_four;
    @(posedge mclk) disable iff (!rstn)
      req.read_en && hit_three_four |=>
        read_data[first_unused_bit] == $past(unused_flag[2]) &&
        read_data[second_unused_bit] == $past(unused_flag[3]);
  endproperty
  a_read_three_four: assert property (p_read_three_four)
    else $error("strings three and four status read back wrong");

  property p_ov_read;
    @(posedge mclk) disable iff (!rstn)
      req.read_en && hit_one_two |=>
        read_data[first_ov_bit] == $past(ov_status[0]);
  endproperty
  a_ov_read: assert property (p_ov_read)
    else $error("string one over-voltage read back wrong");
endmodule
`default_nettype wire

// *** hdl/led_status_pkg.sv ***
// package: register indices, bit positions and carrier types for string status
package led_status_pkg;
  localparam int           num_strings       = 4;
  localparam logic [7:0]   strings_one_two_index   = 8'h05;
  localparam logic [7:0]   strings_three_four_index = 8'h06;
  localparam logic [7:0]   status_reset_value = 8'h00;
  // bit positions within one status register
  localparam int           first_unused_flag  = 7;
  localparam int           second_unused_flag = 6;
  localparam int           first_ov_bit       = 5;
  localparam int           first_open_bit     = 4;
  localparam int           first_unused_bit   = 3;
  localparam int           second_ov_bit      = 2;
  localparam int           second_open_bit    = 1;
  localparam int           second_unused_bit  = 0;
  // over-voltage threshold in millivolts, compared in the analog front end
  localparam int           ov_threshold_mv    = 6750;

  typedef struct packed {
    logic       write_en;
    logic       read_en;
    logic [7:0] index;
    logic [7:0] data;
  } reg_req_type;

  typedef struct packed {
    logic [num_strings-1:0] overvoltage;
    logic [num_strings-1:0] open;
  } string_sense_type;
endpackage

// *** tb/smbus_host_model.sv ***
// behavioural host master issuing register requests to the status block
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
  import led_status_pkg::*;
(
  input  wire logic       mclk,
  output var  reg_req_type req,
  input  wire logic [7:0] read_data,
  input  wire logic       write_ack,
  input  wire logic       fault_flag_n
);
  logic trusted;
  logic fault_seen;
  initial begin
    req = '0;
    trusted = 1'b0;
    fault_seen = 1'b0;
  end
  // one request, held until the taking edge, answer sampled just after it
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [7:0] d, output logic [7:0] rd,
                      output logic ack);
    @(posedge mclk);
    #1;
    req = '{write_en: wr, read_en: !wr,
            index: idx, data: d};
    @(posedge mclk);
    #1;
    rd = read_data;
    ack = write_ack;
    // flag only believed once a mask write was acknowledged
    if (ack) trusted = 1'b1;
    fault_seen = trusted && !fault_flag_n;
    // released index and data lines show the inverse, never the stale value; both enables drop to zero
    req = '{write_en: 1'b0, read_en: 1'b0, index: ~idx, data: ~d};
  endtask
endmodule
`default_nettype wire

// *** tb/tb_led_string_fault_status_regs.sv ***
// self-checking bench for the string fault status registers
`timescale 1ns/1ps
`default_nettype none
module tb_led_string_fault_status_regs
  import led_status_pkg::*;
;
  logic             mclk = 1'b0;
  logic             rstn = 1'b0;
  logic             other_fault = 1'b0;
  reg_req_type      req;
  string_sense_type sense;
  logic [7:0]       read_data, rd;
  logic             write_ack, fault_flag_n, ack;
  logic [1:0]       f12, f34;
  int               err_count = 0;
  int               cmp_count = 0;
  always #20 mclk = ~mclk;
  led_string_fault_status_regs uut (.mclk(mclk), .rstn(rstn), .req(req),
    .sense(sense), .other_fault(other_fault), .read_data(read_data),
    .write_ack(write_ack), .fault_flag_n(fault_flag_n));
  smbus_host_model host (.mclk(mclk), .req(req), .read_data(read_data),
    .write_ack(write_ack), .fault_flag_n(fault_flag_n));
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // f[0] is the first string of the pair
  function automatic logic [7:0] pack2(input logic [1:0] f, ov, op);
    return {f[0], f[1], ov[0] & ~f[0], op[0] & ~f[0], f[0],
            ov[1] & ~f[1], op[1] & ~f[1], f[1]};
  endfunction
  initial begin
    sense = '0;
    repeat (12) @(posedge mclk);
    #1 rstn = 1'b1;
    host.xfer(1'b0, 8'h05, 8'h00, rd, ack);
    check("reset 05", rd, status_reset_value);
    check("host fault early", {7'h0, host.fault_seen}, 8'h00);
    host.xfer(1'b0, 8'h06, 8'h00, rd, ack);
    check("reset 06", rd, status_reset_value);
    for (int p = 0; p < 2; p++) begin
      for (int v = 0; v < 4; v++) begin
        f12 = v[1:0];
        f34 = v[1:0] ^ {p[0], p[0]};
        sense.overvoltage = p[0] ? 4'b0101 : 4'b1010;
        sense.open = ~sense.overvoltage;
        host.xfer(1'b1, 8'h05, {f12[0], f12[1], 6'h3f}, rd, ack);
        check("ack 05", {7'h0, ack}, 8'h01);
        check("host trusts", {7'h0, host.trusted}, 8'h01);
        host.xfer(1'b1, 8'h06, {f34[0], f34[1], 6'h3f}, rd, ack);
        check("ack 06", {7'h0, ack}, 8'h01);
        check("flag at ack", {7'h0, fault_flag_n},
              {7'h0, &{f34, f12}});
        host.xfer(1'b0, 8'h05, 8'h00, rd, ack);
        check("read 05", rd, pack2(f12, sense.overvoltage[1:0],
                                   sense.open[1:0]));
        host.xfer(1'b0, 8'h06, 8'h00, rd, ack);
        check("read 06", rd, pack2(f34, sense.overvoltage[3:2],
                                   sense.open[3:2]));
      end
    end
    // unmapped index: no ack, no effect, reads zero
    host.xfer(1'b1, 8'h07, 8'hff, rd, ack);
    check("ack 07", {7'h0, ack}, 8'h00);
    sense = '0;
    host.xfer(1'b0, 8'h05, 8'h00, rd, ack);
    check("keep 05", rd, pack2(2'b11, 2'b00, 2'b00));
    check("flag idle", {7'h0, fault_flag_n}, 8'h01);
    other_fault = 1'b1;
    host.xfer(1'b0, 8'h07, 8'h00, rd, ack);
    check("read 07", rd, 8'h00);
    check("flag other", {7'h0, fault_flag_n}, 8'h00);
    check("host fault", {7'h0, host.fault_seen}, 8'h01);
    // reset in mid-run: outputs and flags return to their idle values
    @(posedge mclk);
    #1 rstn = 1'b0;
    #1 check("rst flag", {7'h0, fault_flag_n}, 8'h01);
    check("rst ack", {7'h0, write_ack}, 8'h00);
    check("rst data", read_data, status_reset_value);
    repeat (2) @(posedge mclk);
    #1 rstn = 1'b1;
    host.xfer(1'b0, 8'h05, 8'h00, rd, ack);
    check("after rst 05", rd, status_reset_value);
    host.xfer(1'b0, 8'h06, 8'h00, rd, ack);
    check("after rst 06", rd, status_reset_value);
    final_report();
  end
  initial begin
    #200000;
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
